// ===== logic/dcdcr_map.svh
// Purpose: Register offsets, field positions and reset values of the converter control bank.
// Assumes: 8-bit register index and 16-bit register data on the control interface.
// Notes:   Definitions only.
`ifndef DCDCR_MAP_SVH
`define DCDCR_MAP_SVH

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define DCDCR_IDX_COMP      8'hB3
`define DCDCR_IDX_B1_CTL    8'hB4
`define DCDCR_IDX_B1_SEQ    8'hB5
`define DCDCR_IDX_B1_LP     8'hB6
`define DCDCR_IDX_B2_CTL    8'hB7
`define DCDCR_IDX_B2_SEQ    8'hB8
`define DCDCR_IDX_B3_CTL    8'hBA
`define DCDCR_IDX_B3_SEQ    8'hBB
`define DCDCR_IDX_B3_LP     8'hBC
`define DCDCR_IDX_B4_CTL    8'hBD

// ----------------------------------------------------------------------------
// Writable-bit masks
// ----------------------------------------------------------------------------
`define DCDCR_MASK_COMP     16'h5077
`define DCDCR_MASK_COMP_KEY 16'h0077
`define DCDCR_MASK_BCTL     16'hCC7F
`define DCDCR_MASK_B3CTL    16'h0C7F
`define DCDCR_MASK_SEQ      16'hFFC0
`define DCDCR_MASK_LP       16'h737F
`define DCDCR_MASK_B2CTL    16'h535B
`define DCDCR_MASK_B4CTL    16'h0800

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define DCDCR_RST_COMP      16'h0025
`define DCDCR_RST_B1_CTL    16'h000E
`define DCDCR_RST_SEQ       16'h0000
`define DCDCR_RST_B1_LP     16'h1006
`define DCDCR_RST_B3_LP     16'h0006
`define DCDCR_RST_B2_CTL    16'h0018
`define DCDCR_RST_B3_CTL    16'h0000
`define DCDCR_RST_B4_CTL    16'h0000

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DCDCR_F_KEEP_ON     12
`define DCDCR_F_LOW_ACT     14
`define DCDCR_F_CAP_HI      15
`define DCDCR_F_CAP_LO      14
`define DCDCR_F_OVP_DIS     11
`define DCDCR_F_FLOAT       10
`define DCDCR_F_MODE2       14
`define DCDCR_F_ILIM        6
`define DCDCR_F_SLEEP2      12
`define DCDCR_KEY_VALUE     16'h5A5A
`define DCDCR_VCODE_MAX     7'h66
`define DCDCR_SLOT_ACTIVE   4'hF
`define DCDCR_SLOT_NEVER    4'h0

`endif

// ===== logic/dcdcr_pkg.sv
// Purpose: Types shared by the converter control bank.
// Assumes: Constants live in dcdcr_map.svh.
// Notes:   None.
package dcdcr_pkg;
	typedef enum logic [1:0] {
		DCDCR_ACT_IGNORE = 2'h0,
		DCDCR_ACT_CONV   = 2'h1,
		DCDCR_ACT_SYS    = 2'h2,
		DCDCR_ACT_SYS_R  = 2'h3
	} dcdcr_act_type;
	typedef struct packed {
		logic       out_en;
		logic       standby;
		logic       ldo;
		logic       use_image;
		logic       discharge;
		logic       ovp_en;
		logic [6:0] vcode;
	} dcdcr_drive_type;
endpackage

// ===== logic/dcdcr_buck_ctl.sv
// Purpose: Per-buck decode of enable, sleep behaviour, sequencing and fault action.
// Assumes: All inputs are on clk; the power sequencer supplies slot and state.
// Notes:   Output is registered.
`timescale 1ns/1ps
`include "dcdcr_map.svh"
module dcdcr_buck_ctl
	import dcdcr_pkg::*;
(
	input  wire logic            clk,
	input  wire logic            reset_n,
	input  wire logic [15:0]     ctl,
	input  wire logic [15:0]     seq,
	input  wire logic [15:0]     lp,
	input  wire logic            requested,
	input  wire logic            sleep_req,
	input  wire logic            enter_active,
	input  wire logic            enter_off,
	input  wire logic            slot_up,
	input  wire logic            slot_down,
	input  wire logic [3:0]      slot,
	input  wire logic            fault,
	output dcdcr_drive_type      drive,
	output logic                 conv_kill,
	output logic                 sys_kill
);
	typedef struct packed {
		dcdcr_drive_type drive;
		logic            on;
		logic            kill;
		logic            sys;
	} dcdcr_bk_type;
	dcdcr_bk_type st_r, st_nxt;
	logic [3:0]    up_slot;
	logic [3:0]    dn_slot;
	logic [2:0]    hmode;
	dcdcr_act_type act;

	assign up_slot = seq[13:10];
	assign dn_slot = seq[9:6];
	assign hmode   = lp[14:12];
	assign act     = dcdcr_act_type'(seq[15:14]);

	// ------------------------------------------------------------------------
	// Sequencing, fault reaction and sleep shaping.
	// ------------------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.kill = 1'b0;
		st_nxt.sys  = 1'b0;
		if (slot_up && up_slot != `DCDCR_SLOT_NEVER && up_slot != `DCDCR_SLOT_ACTIVE &&
			up_slot == slot) begin
			st_nxt.on = 1'b1; // RULE_08
		end
		if (enter_active && up_slot == `DCDCR_SLOT_ACTIVE) begin
			st_nxt.on = 1'b1; // RULE_08
		end
		if (slot_down && dn_slot != 4'h0 && dn_slot != 4'hF && dn_slot == slot) begin
			st_nxt.on = 1'b0; // RULE_09
		end
		if (enter_off) begin
			st_nxt.on = 1'b0; // RULE_09
		end
		// Reserved action code still kills the system: safest reading.
		if (fault) begin
			unique case (act)
				DCDCR_ACT_IGNORE: st_nxt.kill = 1'b0; // RULE_07
				DCDCR_ACT_CONV: begin
					st_nxt.kill = 1'b1; // RULE_07
					st_nxt.on   = 1'b0;
				end
				DCDCR_ACT_SYS, DCDCR_ACT_SYS_R: st_nxt.sys = 1'b1; // RULE_07
			endcase
		end
		st_nxt.drive.vcode = ctl[6:0]; // RULE_06
		st_nxt.drive.use_image = 1'b0;
		st_nxt.drive.standby = 1'b0;
		st_nxt.drive.ldo = 1'b0;
		st_nxt.drive.out_en = st_r.on && requested;
		if (sleep_req) begin
			unique case (hmode)
				3'h1, 3'h3, 3'h5: st_nxt.drive.use_image = 1'b1; // RULE_10
				default: st_nxt.drive.use_image = 1'b0;
			endcase
			st_nxt.drive.standby = (hmode == 3'h2) || (hmode == 3'h3); // RULE_10
			st_nxt.drive.ldo = (hmode == 3'h4) || (hmode == 3'h5); // RULE_10
			if (hmode == 3'h7) begin
				st_nxt.drive.out_en = 1'b0; // RULE_10
			end
			if (hmode[2:1] != 2'b00 && hmode != 3'h4 && hmode != 3'h5 && hmode != 3'h7) begin
				st_nxt.drive.standby = st_nxt.drive.standby; // Reserved 110: no change.
			end
		end
		if (st_nxt.drive.use_image) begin
			st_nxt.drive.vcode = lp[6:0]; // RULE_13
		end
		st_nxt.drive.discharge = !st_nxt.drive.out_en && !ctl[`DCDCR_F_FLOAT]; // RULE_05
		st_nxt.drive.ovp_en = !ctl[`DCDCR_F_OVP_DIS]; // RULE_20
	end

	// ------------------------------------------------------------------------
	// State register.
	// ------------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign drive     = st_r.drive;
	assign conv_kill = st_r.kill;
	assign sys_kill  = st_r.sys;
endmodule // dcdcr_buck_ctl

// ===== logic/dcdcr_bank.sv
// Purpose: Converter control register bank with decoded converter drive outputs.
// Assumes: Register access on a simple synchronous index/data port of the device.
// Notes:   A state-machine reset pulse restores every field to its default.
//
// Behaviour
// RULE_01: Comparator stays on in sleep when bit12.
// RULE_02: Turn-off threshold field, reset 010, keyed.
// RULE_03: Turn-on threshold field, reset 101, keyed.
// RULE_04: Buck 1 capacitor select in bits 15:14.
// RULE_05: Disabled converter discharges unless float bit.
// RULE_06: Seven-bit voltage code in 25mV steps.
// RULE_07: Fault interrupts always; action per code.
// RULE_08: Start-up slot: never, slot, or active.
// RULE_09: Shutdown slot, or on entering off.
// RULE_10: Sleep behaviour codes shape converter drive.
// RULE_11: Sleep trigger chosen by bits 9:8.
// RULE_12: Sleep GPIO input always forces sleep.
// RULE_13: Image voltage replaces normal in image mode.
// RULE_14: Converter 2 boost or switch mode.
// RULE_15: Converter 2 sleep disables output if set.
// RULE_16: Converter 2 bit6 selects lower current limit.
// RULE_17: Ramp bits; forced 11 for internal feedback.
// RULE_18: Converter 2 feedback source selection.
// RULE_19: State-machine reset restores all defaults.
// RULE_20: Overvoltage protection off when bit11 set; boost2_ovp_en stays tied high, and bit11 of b4_ctl drives nothing.
// RULE_21: Low supply interrupts; hard shutdown if set.
`timescale 1ns/1ps
`include "dcdcr_map.svh"
module dcdcr_bank
	import dcdcr_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               reset_n,
	input  wire logic               sm_reset,
	input  wire logic [7:0]         reg_index,
	input  wire logic [15:0]        reg_wdata,
	input  wire logic               reg_write,
	input  wire logic               reg_read,
	output logic [15:0]             reg_rdata,
	output logic                    reg_rvalid,
	input  wire logic               key_unlocked,
	input  wire logic               sleep_reg_bit,
	input  wire logic               low_power_input_one,
	input  wire logic               low_power_input_two,
	input  wire logic               low_power_input_three,
	input  wire logic               sleep_gpio,
	input  wire logic               supply_below_off,
	input  wire logic [2:0]         conv_requested,
	input  wire logic [2:0]         conv_fault,
	input  wire logic               enter_active,
	input  wire logic               enter_off,
	input  wire logic               slot_up,
	input  wire logic               slot_down,
	input  wire logic [3:0]         slot,
	output dcdcr_drive_type         buck1_drive,
	output dcdcr_drive_type         buck3_drive,
	output logic                    boost2_out_en,
	output logic                    boost2_switch_mode,
	output logic                    boost2_low_current,
	output logic [1:0]              boost2_ramp,
	output logic [1:0]              feedback_source,
	output logic                    boost2_ovp_en,
	output logic [1:0]              buck1_cap_select,
	output logic                    comparator_sleep_keep_on,
	output logic [2:0]              supply_turn_off_threshold,
	output logic [2:0]              supply_turn_on_threshold,
	output logic                    low_supply_irq,
	output logic                    hard_shutdown,
	output logic [2:0]              fault_irq,
	output logic                    converter_shutdown_any
);
	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [15:0] comp;
		logic [15:0] b1_ctl;
		logic [15:0] b1_seq;
		logic [15:0] b1_lp;
		logic [15:0] b2_ctl;
		logic [15:0] b2_seq;
		logic [15:0] b3_ctl;
		logic [15:0] b3_seq;
		logic [15:0] b3_lp;
		logic [15:0] b4_ctl;
		logic [15:0] rdata;
		logic        rvalid;
		logic [2:0]  sync1;
		logic [2:0]  sync2;
		logic        gpio1;
		logic        gpio2;
		logic        low1;
		logic        low2;
		logic [2:0]  sleep;
		logic        b2_on;
		logic [2:0]  fault_irq;
		logic        low_irq;
		logic        hard;
		logic        any_kill;
		logic        b2_out;
		logic [1:0]  b2_ramp;
	} dcdcr_bank_type;

	dcdcr_bank_type st_r, st_nxt;
	dcdcr_drive_type b1_drv, b3_drv;
	logic [2:0] kill, syskill;
	logic       b2_kill, b2_sys;

	// Merge a masked write into a register.
	function automatic logic [15:0] dcdcr_merge(input logic [15:0] old, input logic [15:0] wd,
		input logic [15:0] mask);
		dcdcr_merge = (old & ~mask) | (wd & mask);
	endfunction

	// Pick the sleep source from the two-bit trigger field.
	function automatic logic dcdcr_trig(input logic [1:0] sel, input logic [2:0] lpin,
		input logic regbit, input logic gpio);
		logic src;
		src = regbit;
		unique case (sel)
			2'h0: src = regbit;
			2'h1: src = lpin[0];
			2'h2: src = lpin[1];
			2'h3: src = lpin[2];
		endcase
		dcdcr_trig = src | gpio;
	endfunction

	// ------------------------------------------------------------------------
	// Next-state logic.
	// ------------------------------------------------------------------------
	always_comb begin
		logic [15:0] comp_mask;
		logic [15:0] rd;
		logic [3:0]  b2_up;
		logic [3:0]  b2_dn;
		comp_mask = '0;
		rd = '0;
		st_nxt = st_r;
		b2_up = st_r.b2_seq[13:10];
		b2_dn = st_r.b2_seq[9:6];
		// Pins cross from outside through two flops before use.
		st_nxt.sync1 = {low_power_input_three, low_power_input_two, low_power_input_one};
		st_nxt.sync2 = st_r.sync1;
		st_nxt.gpio1 = sleep_gpio;
		st_nxt.gpio2 = st_r.gpio1;
		st_nxt.low1  = supply_below_off;
		st_nxt.low2  = st_r.low1;
		// Trigger select per converter; the gpio term ORs in unconditionally.
		st_nxt.sleep[0] = dcdcr_trig(st_r.b1_lp[9:8], st_r.sync2, sleep_reg_bit, st_r.gpio2); // RULE_11 RULE_12
		st_nxt.sleep[1] = dcdcr_trig(st_r.b2_ctl[9:8], st_r.sync2, sleep_reg_bit, st_r.gpio2); // RULE_11 RULE_12
		st_nxt.sleep[2] = dcdcr_trig(st_r.b3_lp[9:8], st_r.sync2, sleep_reg_bit, st_r.gpio2); // RULE_11 RULE_12
		// Register writes; threshold bits need the key to be open.
		comp_mask = key_unlocked ? `DCDCR_MASK_COMP : (`DCDCR_MASK_COMP & ~`DCDCR_MASK_COMP_KEY); // RULE_02 RULE_03
		if (reg_write) begin
			unique case (reg_index)
				`DCDCR_IDX_COMP:   st_nxt.comp   = dcdcr_merge(st_r.comp, reg_wdata, comp_mask);
				`DCDCR_IDX_B1_CTL: st_nxt.b1_ctl = dcdcr_merge(st_r.b1_ctl, reg_wdata, `DCDCR_MASK_BCTL);
				`DCDCR_IDX_B1_SEQ: st_nxt.b1_seq = dcdcr_merge(st_r.b1_seq, reg_wdata, `DCDCR_MASK_SEQ);
				`DCDCR_IDX_B1_LP:  st_nxt.b1_lp  = dcdcr_merge(st_r.b1_lp, reg_wdata, `DCDCR_MASK_LP);
				`DCDCR_IDX_B2_CTL: st_nxt.b2_ctl = dcdcr_merge(st_r.b2_ctl, reg_wdata, `DCDCR_MASK_B2CTL);
				`DCDCR_IDX_B2_SEQ: st_nxt.b2_seq = dcdcr_merge(st_r.b2_seq, reg_wdata, `DCDCR_MASK_SEQ);
				`DCDCR_IDX_B3_CTL: st_nxt.b3_ctl = dcdcr_merge(st_r.b3_ctl, reg_wdata, `DCDCR_MASK_B3CTL);
				`DCDCR_IDX_B3_SEQ: st_nxt.b3_seq = dcdcr_merge(st_r.b3_seq, reg_wdata, `DCDCR_MASK_SEQ);
				`DCDCR_IDX_B3_LP:  st_nxt.b3_lp  = dcdcr_merge(st_r.b3_lp, reg_wdata, `DCDCR_MASK_LP);
				`DCDCR_IDX_B4_CTL: st_nxt.b4_ctl = dcdcr_merge(st_r.b4_ctl, reg_wdata, `DCDCR_MASK_B4CTL);
				default: st_nxt.comp = st_r.comp; // Unmapped writes are dropped.
			endcase
		end
		// Reads: unmapped indices return zero.
		unique case (reg_index)
			`DCDCR_IDX_COMP:   rd = st_r.comp;
			`DCDCR_IDX_B1_CTL: rd = st_r.b1_ctl;
			`DCDCR_IDX_B1_SEQ: rd = st_r.b1_seq;
			`DCDCR_IDX_B1_LP:  rd = st_r.b1_lp;
			`DCDCR_IDX_B2_CTL: rd = st_r.b2_ctl;
			`DCDCR_IDX_B2_SEQ: rd = st_r.b2_seq;
			`DCDCR_IDX_B3_CTL: rd = st_r.b3_ctl;
			`DCDCR_IDX_B3_SEQ: rd = st_r.b3_seq;
			`DCDCR_IDX_B3_LP:  rd = st_r.b3_lp;
			`DCDCR_IDX_B4_CTL: rd = st_r.b4_ctl;
			default:           rd = 16'h0000;
		endcase
		st_nxt.rvalid = reg_read;
		if (reg_read) begin
			st_nxt.rdata = rd;
		end
		// Converter 2 sequencing mirrors the buck sequencer.
		if (slot_up && b2_up != 4'h0 && b2_up != 4'hF && b2_up == slot) begin
			st_nxt.b2_on = 1'b1; // RULE_08
		end
		if (enter_active && b2_up == `DCDCR_SLOT_ACTIVE) begin
			st_nxt.b2_on = 1'b1; // RULE_08
		end
		if ((slot_down && b2_dn != 4'h0 && b2_dn != 4'hF && b2_dn == slot) || enter_off) begin
			st_nxt.b2_on = 1'b0; // RULE_09
		end
		if (b2_kill) begin
			st_nxt.b2_on = 1'b0; // RULE_07
		end
		// Sleep field 1 disables converter 2; 0 keeps it running.
		st_nxt.b2_out = st_r.b2_on && conv_requested[1] &&
			!(st_r.sleep[1] && st_r.b2_ctl[`DCDCR_F_SLEEP2]); // RULE_15
		// Fault pulses always interrupt whatever the action code.
		st_nxt.fault_irq = conv_fault; // RULE_07
		st_nxt.any_kill = |kill || b2_kill;
		// Low supply: interrupt always, hard shutdown if the action bit is set.
		st_nxt.low_irq = st_r.low2; // RULE_21
		st_nxt.hard = (st_r.low2 && st_r.comp[`DCDCR_F_LOW_ACT]) || |syskill || b2_sys; // RULE_21 RULE_07
		// The state-machine reset outranks any write in the same cycle.
		if (sm_reset) begin
			st_nxt.comp   = `DCDCR_RST_COMP; // RULE_19
			st_nxt.b1_ctl = `DCDCR_RST_B1_CTL;
			st_nxt.b1_seq = `DCDCR_RST_SEQ;
			st_nxt.b1_lp  = `DCDCR_RST_B1_LP;
			st_nxt.b2_ctl = `DCDCR_RST_B2_CTL;
			st_nxt.b2_seq = `DCDCR_RST_SEQ;
			st_nxt.b3_ctl = `DCDCR_RST_B3_CTL;
			st_nxt.b3_seq = `DCDCR_RST_SEQ;
			st_nxt.b3_lp  = `DCDCR_RST_B3_LP;
			st_nxt.b4_ctl = `DCDCR_RST_B4_CTL;
			st_nxt.b2_on  = 1'b0;
		end
		// Ramp follows the next control value so it never lags the feedback field.
		st_nxt.b2_ramp = (st_nxt.b2_ctl[1:0] == 2'h3) ? 2'h3 : st_nxt.b2_ctl[4:3]; // RULE_17
	end

	// ------------------------------------------------------------------------
	// Registers.
	// ------------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st_r        <= '0;
			st_r.comp   <= `DCDCR_RST_COMP; // RULE_02 RULE_03
			st_r.b1_ctl <= `DCDCR_RST_B1_CTL;
			st_r.b1_lp  <= `DCDCR_RST_B1_LP;
			st_r.b2_ctl <= `DCDCR_RST_B2_CTL;
			st_r.b2_ramp <= 2'h3;
			st_r.b3_lp  <= `DCDCR_RST_B3_LP;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------------------
	// Per-buck decode.
	// ------------------------------------------------------------------------
	dcdcr_buck_ctl u_buck1 (
		.clk          (clk),
		.reset_n      (reset_n && !sm_reset),
		.ctl          (st_r.b1_ctl),
		.seq          (st_r.b1_seq),
		.lp           (st_r.b1_lp),
		.requested    (conv_requested[0]),
		.sleep_req    (st_r.sleep[0]),
		.enter_active (enter_active),
		.enter_off    (enter_off),
		.slot_up      (slot_up),
		.slot_down    (slot_down),
		.slot         (slot),
		.fault        (conv_fault[0]),
		.drive        (b1_drv),
		.conv_kill    (kill[0]),
		.sys_kill     (syskill[0])
	);
	dcdcr_buck_ctl u_buck3 (
		.clk          (clk),
		.reset_n      (reset_n && !sm_reset),
		.ctl          (st_r.b3_ctl),
		.seq          (st_r.b3_seq),
		.lp           (st_r.b3_lp),
		.requested    (conv_requested[2]),
		.sleep_req    (st_r.sleep[2]),
		.enter_active (enter_active),
		.enter_off    (enter_off),
		.slot_up      (slot_up),
		.slot_down    (slot_down),
		.slot         (slot),
		.fault        (conv_fault[2]),
		.drive        (b3_drv),
		.conv_kill    (kill[2]),
		.sys_kill     (syskill[2])
	);
	assign kill[1]    = 1'b0;
	assign syskill[1] = 1'b0;
	// Converter 2 fault action decoded inline.
	assign b2_kill = conv_fault[1] && st_r.b2_seq[15:14] == 2'h1; // RULE_07
	assign b2_sys  = conv_fault[1] && st_r.b2_seq[15]; // RULE_07

	// ------------------------------------------------------------------------
	// Outputs, all from flops except boost2_ovp_en, tied high.
	// ------------------------------------------------------------------------
	assign reg_rdata                 = st_r.rdata;
	assign reg_rvalid                = st_r.rvalid;
	assign buck1_drive               = b1_drv;
	assign buck3_drive               = b3_drv;
	assign boost2_out_en             = st_r.b2_out;
	assign boost2_switch_mode        = st_r.b2_ctl[`DCDCR_F_MODE2]; // RULE_14
	assign boost2_low_current        = st_r.b2_ctl[`DCDCR_F_ILIM]; // RULE_16
	assign boost2_ramp               = st_r.b2_ramp;
	assign feedback_source           = st_r.b2_ctl[1:0]; // RULE_18
	assign boost2_ovp_en             = 1'b1;
	assign buck1_cap_select          = st_r.b1_ctl[`DCDCR_F_CAP_HI:`DCDCR_F_CAP_LO]; // RULE_04
	assign comparator_sleep_keep_on  = st_r.comp[`DCDCR_F_KEEP_ON]; // RULE_01
	assign supply_turn_off_threshold = st_r.comp[6:4];
	assign supply_turn_on_threshold  = st_r.comp[2:0];
	assign low_supply_irq            = st_r.low_irq;
	assign hard_shutdown             = st_r.hard;
	assign fault_irq                 = st_r.fault_irq;
	assign converter_shutdown_any    = st_r.any_kill;
endmodule // dcdcr_bank

// ===== testbench/dcdcr_bank_properties.sv
// Purpose: Port-level timing checks for the converter control bank.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound into the bank after the module.
`timescale 1ns/1ps
module dcdcr_bank_chk (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        sm_reset,
	input wire logic [7:0]  reg_index,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_write,
	input wire logic        key_unlocked,
	input wire logic [2:0]  conv_fault,
	input wire logic [2:0]  fault_irq,
	input wire logic        boost2_switch_mode,
	input wire logic [1:0]  boost2_ramp,
	input wire logic [1:0]  feedback_source,
	input wire logic [1:0]  buck1_cap_select,
	input wire logic        comparator_sleep_keep_on,
	input wire logic [2:0]  supply_turn_off_threshold,
	input wire logic [2:0]  supply_turn_on_threshold
);
// --------
// Write decode
// --------
// A state-machine reset wins over a write, so it masks the write here.
logic wr_comp;
logic wr_b1;
logic wr_b2;
assign wr_comp = reg_write && !sm_reset && reg_index == 8'hB3;
assign wr_b1 = reg_write && !sm_reset && reg_index == 8'hB4;
assign wr_b2 = reg_write && !sm_reset && reg_index == 8'hB7;
default clocking @(posedge clk); endclocking
default disable iff (!reset_n);
// --------
// Properties
// --------
// Each but AST_RAMP ties a decoded output to the write or event that caused it; AST_RAMP ties the ramp to the feedback field.
AST_KEEP_ON: assert property (wr_comp |=> comparator_sleep_keep_on == $past(reg_wdata[12]))
	else $error("keep-on bit did not follow write");
AST_OFF_KEYED: assert property (wr_comp && !key_unlocked |=> $stable(supply_turn_off_threshold))
	else $error("turn-off threshold changed while locked");
AST_ON_KEY: assert property (wr_comp && key_unlocked |=> supply_turn_on_threshold == $past(reg_wdata[2:0]))
	else $error("turn-on threshold did not follow write");
AST_CAP: assert property (wr_b1 |=> buck1_cap_select == $past(reg_wdata[15:14]))
	else $error("capacitor select did not follow write");
AST_MODE2: assert property (wr_b2 |=> boost2_switch_mode == $past(reg_wdata[14]))
	else $error("mode did not follow write");
AST_RAMP: assert property (feedback_source == 2'h3 |-> boost2_ramp == 2'h3)
	else $error("ramp not forced for internal feedback");
AST_SMRESET: assert property (sm_reset |=> supply_turn_off_threshold == 3'h2 && supply_turn_on_threshold == 3'h5 && boost2_ramp == 2'h3)
	else $error("defaults not restored");
AST_FAULT: assert property (conv_fault[0] |=> fault_irq[0])
	else $error("fault gave no interrupt");
COV_LOCKED: cover property (wr_comp && !key_unlocked);
COV_SMRESET: cover property (sm_reset);
COV_FAULT: cover property (conv_fault[0]);
endmodule // dcdcr_bank_chk
bind dcdcr_bank dcdcr_bank_chk u_chk (.clk, .reset_n, .sm_reset, .reg_index, .reg_wdata,
	.reg_write, .key_unlocked, .conv_fault, .fault_irq, .boost2_switch_mode, .boost2_ramp,
	.feedback_source, .buck1_cap_select, .comparator_sleep_keep_on,
	.supply_turn_off_threshold, .supply_turn_on_threshold);

// ===== testbench/testbench.sv
// Purpose: Self-checking bench for the converter control bank.
// Assumes: Register port takes a request on the clock edge; read data one cycle later.
// Notes:   Register rows first, then hand-written cases.
`timescale 1ns/1ps
module testbench
	import dcdcr_pkg::*;
;
logic clk = 1'h0, reset_n = 1'h0, sm_reset = 1'h0, reg_write = 1'h0, reg_read = 1'h0;
logic key_unlocked = 1'h1, sleep_reg_bit = 1'h0, low_power_input_one = 1'h0;
logic low_power_input_two = 1'h0, low_power_input_three = 1'h0, sleep_gpio = 1'h0;
logic supply_below_off = 1'h0, enter_active = 1'h0, enter_off = 1'h0;
logic [7:0] reg_index = 8'h00;
logic [15:0] reg_wdata = 16'h0000;
logic [2:0] conv_requested = 3'h0, conv_fault = 3'h0;
logic [3:0] slot = 4'h0;
logic [15:0] reg_rdata;
logic [2:0] fault_irq;
logic [1:0] boost2_ramp, feedback_source;
logic comparator_sleep_keep_on, low_supply_irq, hard_shutdown, boost2_switch_mode;
logic boost2_low_current;
dcdcr_drive_type buck1_drive;
int n_mismatch = 0, comparisons = 0, cyc = 0;
// --------
// Register rows: index, reset value, readback after writing all ones
// --------
logic [7:0] t_idx [11] = '{8'hB3, 8'hB4, 8'hB5, 8'hB6, 8'hB7, 8'hB8, 8'hBA, 8'hBB,
	8'hBC, 8'hBD, 8'hB9};
logic [15:0] t_rst [11] = '{16'h0025, 16'h000E, 16'h0000, 16'h1006, 16'h0018, 16'h0000,
	16'h0000, 16'h0000, 16'h0006, 16'h0000, 16'h0000};
logic [15:0] t_all [11] = '{16'h5077, 16'hCC7F, 16'hFFC0, 16'h737F, 16'h535B, 16'hFFC0,
	16'h0C7F, 16'hFFC0, 16'h737F, 16'h0800, 16'h0000};
dcdcr_bank uut (.clk, .reset_n, .sm_reset, .reg_index, .reg_wdata, .reg_write, .reg_read,
	.reg_rdata, .reg_rvalid(), .key_unlocked, .sleep_reg_bit, .low_power_input_one,
	.low_power_input_two, .low_power_input_three, .sleep_gpio, .supply_below_off,
	.conv_requested, .conv_fault, .enter_active, .enter_off, .slot_up(1'h0),
	.slot_down(1'h0), .slot, .buck1_drive, .buck3_drive(), .boost2_out_en(),
	.boost2_switch_mode, .boost2_low_current, .boost2_ramp, .feedback_source,
	.boost2_ovp_en(), .buck1_cap_select(), .comparator_sleep_keep_on,
	.supply_turn_off_threshold(), .supply_turn_on_threshold(), .low_supply_irq,
	.hard_shutdown, .fault_irq, .converter_shutdown_any());
// Clock at 50 MHz; the cycle ceiling cuts a hang short.
always #10 clk = ~clk;
always @(posedge clk) begin
	cyc++;
	if (cyc == 20000) begin
		n_mismatch++;
		stop_test();
	end
end
// --------
// Tasks
// --------
task automatic chk(string n, logic [15:0] e, logic [15:0] g);
	comparisons++;
	if (g !== e) begin
		n_mismatch++;
		$display("wrong value %s expected %h seen %h", n, e, g);
	end
endtask
task automatic wr(logic [7:0] i, logic [15:0] d);
	@(posedge clk) {reg_index, reg_wdata, reg_write} <= {i, d, 1'h1};
	@(posedge clk) reg_write <= 1'h0;
endtask
// Read data is settled just after the edge following the request.
task automatic rd(logic [7:0] i, logic [15:0] e);
	@(posedge clk) {reg_index, reg_read} <= {i, 1'h1};
	@(posedge clk) reg_read <= 1'h0;
	#1 chk("rdata", e, reg_rdata);
endtask
task automatic tick(int n);
	repeat (n) @(posedge clk);
	#1;
endtask
task automatic stop_test();
	$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
	if (n_mismatch == 0 && comparisons > 0)
		$display("SIMULATION PASSED");
	else
		$display("SIMULATION FAILED");
	$finish;
endtask
// --------
// Main sequence
// --------
initial begin
	repeat (5) @(posedge clk);
	reset_n <= 1'h1;
	foreach (t_idx[i]) rd(t_idx[i], t_rst[i]);
	foreach (t_idx[i]) begin
		wr(t_idx[i], 16'hFFFF);
		rd(t_idx[i], t_all[i]);
	end
	// Locked key keeps the thresholds but lets the other bits change.
	key_unlocked <= 1'h0;
	wr(8'hB3, 16'h4000);
	rd(8'hB3, 16'h4077);
	chk("keep_on", 16'h0, 16'(comparator_sleep_keep_on));
	supply_below_off <= 1'h1;
	tick(6);
	chk("low_supply", 16'h3, 16'({low_supply_irq, hard_shutdown}));
	supply_below_off <= 1'h0;
	// Every fault action code still raises the interrupt.
	for (int a = 0; a < 4; a++) begin
		wr(8'hB5, 16'(a) << 14);
		@(posedge clk) conv_fault <= 3'h1;
		@(posedge clk) conv_fault <= 3'h0;
		#1 chk("fault_irq", 16'h1, 16'(fault_irq));
	end
	// Sleep behaviour codes, with image 20h against normal 10h.
	wr(8'hB4, 16'h0010);
	sleep_reg_bit <= 1'h1;
	for (int c = 0; c < 8; c++) begin
		wr(8'hB6, (16'(c) << 12) | 16'h0020);
		tick(6);
		chk("mode", 16'({c inside {2, 3}, c inside {4, 5}, c inside {1, 3, 5}}),
			16'({buck1_drive.standby, buck1_drive.ldo, buck1_drive.use_image}));
		chk("vcode", c inside {1, 3, 5} ? 16'h20 : 16'h10, 16'(buck1_drive.vcode));
	end
	// Only the selected trigger source puts the converter to sleep.
	for (int t = 0; t < 4; t++) begin
		wr(8'hB6, 16'h1020 | (16'(t) << 8));
		for (int s = 0; s < 2; s++) begin
			{low_power_input_three, low_power_input_two, low_power_input_one,
				sleep_reg_bit} <= s ? 4'h1 << t : ~(4'h1 << t);
			tick(6);
			chk("trigger", 16'(s), 16'(buck1_drive.use_image));
		end
	end
	{low_power_input_three, low_power_input_two, low_power_input_one, sleep_reg_bit} <= 4'h0;
	sleep_gpio <= 1'h1;
	tick(6);
	chk("gpio_sleep", 16'h1, 16'(buck1_drive.use_image));
	sleep_gpio <= 1'h0;
	// Start slot never, then on entering active, then shut on entering off.
	conv_requested <= 3'h1;
	for (int k = 0; k < 2; k++) begin
		wr(8'hB5, k ? 16'h3C00 : 16'h0000);
		@(posedge clk) enter_active <= 1'h1;
		@(posedge clk) enter_active <= 1'h0;
		tick(3);
		chk("out_en", 16'(k), 16'(buck1_drive.out_en));
	end
	chk("ovp_en", 16'h1, 16'(buck1_drive.ovp_en));
	@(posedge clk) enter_off <= 1'h1;
	@(posedge clk) enter_off <= 1'h0;
	tick(3);
	chk("off", 16'h1, 16'({buck1_drive.out_en, buck1_drive.discharge}));
	// Converter 2 fields, then forced ramp on internal feedback.
	wr(8'hB7, 16'h4041);
	tick(1);
	chk("boost2", 16'h31, 16'({boost2_switch_mode, boost2_low_current, boost2_ramp,
		feedback_source}));
	wr(8'hB7, 16'h0003);
	tick(1);
	chk("ramp", 16'h3, 16'(boost2_ramp));
	@(posedge clk) sm_reset <= 1'h1;
	@(posedge clk) sm_reset <= 1'h0;
	foreach (t_idx[i]) rd(t_idx[i], t_rst[i]);
	stop_test();
end
endmodule // testbench
